// [rtl/aipp_map.svh]
/*
 * register offsets, field positions, reset values and timing figures of
 * the analog input post-processing block.
 * assumes word addressing on a 16-bit register port.
 */
`ifndef AIPP_MAP_SVH
`define AIPP_MAP_SVH

// ==========================================================
// register offsets (word index)
`define AIPP_OFS_PEAK_HOLD 8'h00
`define AIPP_OFS_INPUT_USE 8'h01
`define AIPP_OFS_MODE 8'h02
`define AIPP_OFS_DISC_STATUS 8'h03
`define AIPP_OFS_RESP_TIME 8'h04
`define AIPP_OFS_CFG_BASE 8'h10
`define AIPP_OFS_SCALE_BASE 8'h20
`define AIPP_OFS_DATA_BASE 8'h40

// ==========================================================
// fields and reset values
`define AIPP_MODE_FAST_BIT 0
`define AIPP_MODE_SEL_LSB 4
`define AIPP_CFG_AVG_LSB 0
`define AIPP_CFG_RNG_LSB 4
`define AIPP_RST_INPUT_USE 16'hFFFF
`define AIPP_RST_CFG 16'h0000
`define AIPP_AVG_TWO 3'h0
`define AIPP_AVG_NONE 3'h1

// ==========================================================
// conversion figures
`define AIPP_CLK_NS 10
`define AIPP_CONV_SLOW_NS 1000000
`define AIPP_CONV_FAST_NS 250000
`define AIPP_SPAN 4000
`define AIPP_BIPOLAR_MIN (-2000)
`define AIPP_DISC_THR_SLOW (-700)
`define AIPP_DISC_THR_FAST (-1400)
`define AIPP_SAT_MAX 32767
`define AIPP_SAT_MIN (-32768)

`endif

// [rtl/aipp_pkg.sv]
/*
 * types of the analog input post-processing block.
 * assumes aipp_map.svh carries the numeric constants.
 */
package aipp_pkg;

	// ==========================================================
	// input signal ranges
	typedef enum logic [2:0]
	{
		RNG_BIPOLAR_10V,
		RNG_0_10V,
		RNG_1_5V,
		RNG_0_5V,
		RNG_4_20MA
	} aipp_range_t;

	// ==========================================================
	// one conversion result from the converter front end
	typedef struct packed
	{
		logic valid;
		logic [3:0] chan;
		logic signed [15:0] data;
	} aipp_sample_t;

endpackage

// [rtl/aipp_postproc.sv]
/*
 * analog input post-processing: conversion scheduling, moving average,
 * peak hold, disconnection detection, zero forcing and slow-mode linear scaling
 * for sixteen inputs, plus the register port.
 * assumes a converter front end on REF_CLK that takes CONV_START and
 * returns offset/gain corrected data as one SAMPLE pulse per conversion.
 */
// Decided for this implementation: the plain strobed port and the register offsets.
`include "aipp_map.svh"

module aipp_postproc
	import aipp_pkg::*;
#(
	parameter int SLOW_CYCLES = `AIPP_CONV_SLOW_NS / `AIPP_CLK_NS,
	parameter int FAST_CYCLES = `AIPP_CONV_FAST_NS / `AIPP_CLK_NS
)
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	input wire aipp_sample_t SAMPLE,
	output logic CONV_START,
	output logic [3:0] CONV_CHAN,
	output logic CONV_FAST,
	output logic [15:0] DISC_FLAGS
);

	// ==========================================================
	// software visible state
	logic [15:0] peak_en;
	logic [15:0] next_peak_en;
	logic [15:0] input_use;
	logic [15:0] next_input_use;
	logic [15:0] mode;
	logic [15:0] next_mode;
	logic [15:0] cfg [16];
	logic [15:0] next_cfg [16];
	logic signed [15:0] lim [32];
	logic signed [15:0] next_lim [32];
	logic [15:0] rdata;
	logic [15:0] next_rdata;

	// per-input processing state
	logic signed [22:0] sum [16];
	logic signed [22:0] next_sum [16];
	logic [5:0] ptr [16];
	logic [5:0] next_ptr [16];
	logic [6:0] cnt [16];
	logic [6:0] next_cnt [16];
	logic signed [15:0] first [16];
	logic signed [15:0] next_first [16];
	logic signed [15:0] held [16];
	logic signed [15:0] next_held [16];
	logic [15:0] held_ok;
	logic [15:0] next_held_ok;
	logic [15:0] disc;
	logic [15:0] next_disc;
	logic signed [15:0] dout [16];
	logic signed [15:0] next_dout [16];

	// history buffers, 64 deep per input
	logic signed [15:0] hist [1024];

	// scheduler
	logic [16:0] div;
	logic [16:0] next_div;
	logic [3:0] chan;
	logic [3:0] next_chan;
	logic start;
	logic next_start;

	// per-input decode
	logic [2:0] shift_w [16];
	logic [15:0] detect_w;

	logic fast;
	assign fast = mode[`AIPP_MODE_FAST_BIT];

	// ==========================================================
	// depth code to shift count and range decode per input
	genvar gk;
	generate
		for (gk = 0; gk < 16; gk++)
		begin : g_dec
			logic [2:0] code;
			aipp_range_t rng;
			assign code = cfg[gk][`AIPP_CFG_AVG_LSB +: 3];
			assign rng = aipp_range_t'(cfg[gk][`AIPP_CFG_RNG_LSB +: 3]);
			// codes above six are treated as 64 deep
			assign shift_w[gk] = (code == `AIPP_AVG_TWO) ? 3'h1 :
				(code == `AIPP_AVG_NONE) ? 3'h0 :
				(code > 3'h6) ? 3'h6 : code;
			// only the live-zero ranges can tell a broken wire
			assign detect_w[gk] = (rng == RNG_1_5V) ||
				(rng == RNG_4_20MA);
		end
	endgenerate

	// ==========================================================
	// response time of the selected input, in 1/8 ms fast or 1/2 ms slow
	function automatic logic [15:0] resp_time(input logic [2:0] sh,
		input logic [4:0] m);
		logic [15:0] n;
		logic [15:0] mw;
		n = 16'h0001 << sh;
		mw = {11'h000, m};
		if (mw <= 16'h0001)
			resp_time = (n == 16'h0001) ? 16'h0006 :
				16'((n + 16'h0003) << 1);
		else if (n <= 16'h0002)
			resp_time = 16'((n * (mw + 16'h0002)) << 1);
		else
			resp_time = 16'((((n - 16'h0002) * mw) << 1) + 16'h0015);
	endfunction

	// ==========================================================
	// linear scaling of one averaged value into the user limits
	function automatic logic signed [15:0] scale(
		input logic signed [15:0] v, input logic signed [15:0] lo,
		input logic signed [15:0] hi, input logic bip);
		logic signed [16:0] off;
		logic signed [16:0] span;
		logic signed [33:0] prod;
		logic signed [33:0] q;
		logic signed [33:0] r;
		// bipolar data starts at -2000, so shift it onto the span
		off = bip ? 17'(v - 16'(`AIPP_BIPOLAR_MIN)) : 17'(v);
		span = 17'(hi) - 17'(lo);
		prod = 34'(off) * 34'(span);
		q = prod / 34'sd4000;
		r = 34'(lo) + q;
		// 105% of a wide span can leave 16 bits, so saturate
		if (r > 34'sd32767)
			scale = 16'sh7FFF;
		else if (r < -34'sd32768)
			scale = 16'sh8000;
		else
			scale = 16'(r);
	endfunction

	// ==========================================================
	// enabled-input count
	logic [4:0] words;
	always_comb
	begin
		words = 5'h00;
		for (int i = 0; i < 16; i++)
			words = words + {4'h0, input_use[i]};
	end

	// ==========================================================
	// sample path: averaging, detection, hold, zero and scaling
	logic [3:0] sc;
	logic signed [15:0] sd;
	logic [2:0] ssh;
	logic [6:0] sn;
	logic signed [15:0] first_v;
	logic [5:0] ptr_v;
	logic signed [22:0] base_v;
	logic signed [15:0] old_v;
	logic signed [22:0] sum_v;
	logic signed [15:0] mean_v;
	logic signed [15:0] live_v;
	logic signed [15:0] thr_v;
	logic lost_v;
	logic [9:0] widx;
	assign sc = SAMPLE.chan;
	assign sd = SAMPLE.data;
	assign widx = {sc, ptr_v};

	always_comb
	begin
		ssh = shift_w[sc];
		sn = 7'h01 << ssh;
		first_v = (cnt[sc] == 7'h00) ? sd : first[sc];
		ptr_v = (cnt[sc] == 7'h00) ? 6'h00 : ptr[sc];
		base_v = (cnt[sc] == 7'h00) ? (23'(sd) <<< ssh) : sum[sc];
		old_v = (cnt[sc] < sn) ? first_v : hist[widx];
		sum_v = base_v - 23'(old_v) + 23'(sd);
		mean_v = 16'(sum_v >>> ssh);
		// thresholds sit on corrected data, so calibration moves them
		thr_v = fast ? 16'(`AIPP_DISC_THR_FAST) :
			16'(`AIPP_DISC_THR_SLOW);
		lost_v = detect_w[sc] && (sd < thr_v);
		// peak hold shows the larger of the held and the averaged value
		live_v = (peak_en[sc] && held_ok[sc] && !(mean_v > held[sc])) ?
			held[sc] : mean_v;
	end

	// ==========================================================
	// next state of the per-input pipeline and of the registers
	always_comb
	begin
		next_peak_en = peak_en;
		next_input_use = input_use;
		next_mode = mode;
		next_cfg = cfg;
		next_lim = lim;
		next_sum = sum;
		next_ptr = ptr;
		next_cnt = cnt;
		next_first = first;
		next_held = held;
		next_held_ok = held_ok;
		next_disc = disc;
		next_dout = dout;
		if (SAMPLE.valid)
		begin
			next_disc[sc] = lost_v;
			if (lost_v)
			begin
				// averaging restarts from one sample after recovery
				next_cnt[sc] = 7'h00;
				if (!peak_en[sc])
					next_dout[sc] = 16'sh0000;
				else if (!held_ok[sc])
					next_dout[sc] = 16'sh0000;
			end
			else
			begin
				next_sum[sc] = sum_v;
				next_first[sc] = first_v;
				next_ptr[sc] = (ptr_v + 6'h01) & 6'(sn - 7'h01);
				next_cnt[sc] = (cnt[sc] < sn) ? cnt[sc] + 7'h01 : sn;
				if (peak_en[sc])
				begin
					// signed compare so negative readings rank right
					if (!held_ok[sc] || (mean_v > held[sc]))
						next_held[sc] = mean_v;
					next_held_ok[sc] = 1'b1;
				end
				if (!fast && !(lim[{sc, 1'b0}] == 16'sh0000 &&
					lim[{sc, 1'b1}] == 16'sh0000))
					next_dout[sc] = scale(live_v, lim[{sc, 1'b0}],
						lim[{sc, 1'b1}],
						cfg[sc][`AIPP_CFG_RNG_LSB +: 3] == 3'(RNG_BIPOLAR_10V));
				else
					next_dout[sc] = live_v;
			end
		end
		// a cleared enable drops the held value at once
		for (int i = 0; i < 16; i++)
			if (!peak_en[i])
				next_held_ok[i] = 1'b0;
		if (REG_WR)
		begin
			if (REG_ADDR == `AIPP_OFS_PEAK_HOLD)
				next_peak_en = REG_WDATA;
			if (REG_ADDR == `AIPP_OFS_INPUT_USE)
				next_input_use = REG_WDATA;
			if (REG_ADDR == `AIPP_OFS_MODE)
				next_mode = REG_WDATA;
			if (REG_ADDR[7:4] == 4'h1)
			begin
				next_cfg[REG_ADDR[3:0]] = REG_WDATA;
				// a new depth invalidates the history
				next_cnt[REG_ADDR[3:0]] = 7'h00;
			end
			if (REG_ADDR[7:5] == 3'h1)
				next_lim[REG_ADDR[4:0]] = REG_WDATA;
		end
	end

	// ==========================================================
	// register read mux, answer stands one cycle after the strobe
	always_comb
	begin
		next_rdata = 16'h0000;
		if (REG_RD)
		begin
			case (REG_ADDR[7:4])
				4'h0:
					case (REG_ADDR[3:0])
						4'h0: next_rdata = peak_en;
						4'h1: next_rdata = input_use;
						4'h2: next_rdata = mode;
						4'h3: next_rdata = disc;
						4'h4: next_rdata = resp_time(
							shift_w[mode[`AIPP_MODE_SEL_LSB +: 4]], words);
						default: next_rdata = 16'h0000;
					endcase
				4'h1: next_rdata = cfg[REG_ADDR[3:0]];
				4'h2: next_rdata = lim[{1'b0, REG_ADDR[3:0]}];
				4'h3: next_rdata = lim[{1'b1, REG_ADDR[3:0]}];
				4'h4: next_rdata = dout[REG_ADDR[3:0]];
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// conversion tick divider and round robin over enabled inputs
	always_comb
	begin
		next_div = div + 17'h00001;
		next_start = 1'b0;
		next_chan = chan;
		if (div >= 17'((fast ? FAST_CYCLES : SLOW_CYCLES) - 1))
		begin
			next_div = 17'h00000;
			for (int i = 16; i >= 1; i--)
				if (input_use[4'(chan + 4'(i))])
					next_chan = 4'(chan + 4'(i));
			next_start = |input_use;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			peak_en <= 16'h0000;
			input_use <= `AIPP_RST_INPUT_USE;
			mode <= 16'h0000;
			rdata <= 16'h0000;
			held_ok <= 16'h0000;
			disc <= 16'h0000;
			div <= 17'h00000;
			chan <= 4'hF;
			start <= 1'b0;
			for (int i = 0; i < 16; i++)
			begin
				cfg[i] <= `AIPP_RST_CFG;
				sum[i] <= 23'sh000000;
				ptr[i] <= 6'h00;
				cnt[i] <= 7'h00;
				first[i] <= 16'sh0000;
				held[i] <= 16'sh0000;
				dout[i] <= 16'sh0000;
			end
			for (int i = 0; i < 32; i++)
				lim[i] <= 16'sh0000;
		end
		else
		begin
			peak_en <= next_peak_en;
			input_use <= next_input_use;
			mode <= next_mode;
			rdata <= next_rdata;
			held_ok <= next_held_ok;
			disc <= next_disc;
			div <= next_div;
			chan <= next_chan;
			start <= next_start;
			cfg <= next_cfg;
			lim <= next_lim;
			sum <= next_sum;
			ptr <= next_ptr;
			cnt <= next_cnt;
			first <= next_first;
			held <= next_held;
			dout <= next_dout;
		end
	end

	// history write; contents need no reset since cnt masks them
	always_ff @(posedge REF_CLK)
	begin
		if (SAMPLE.valid && !lost_v)
			hist[widx] <= sd;
	end

	// ==========================================================
	// outputs
	assign REG_RDATA = rdata;
	assign CONV_START = start;
	assign CONV_CHAN = chan;
	assign CONV_FAST = fast;
	assign DISC_FLAGS = disc;

endmodule // aipp_postproc

// [verification/aipp_front_model.sv]
/*
 * behavioural converter front end for the post-processing block.
 * assumes one level from the bench stands for every input channel.
 */
module aipp_front_model
	import aipp_pkg::*;
#(
	parameter int LAT = 3
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [3:0] chan,
	input wire logic signed [15:0] level,
	output aipp_sample_t sample
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	logic [3:0] ch;
	// ==========================================================
	// conversion pipeline
	// idle cycles flip chan and data so stale values never look valid
	always @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= 0;
			sample <= '0;
		end
		else
		begin
			if (start)
			begin
				cnt <= LAT;
				ch <= chan;
			end
			else if (cnt > 0)
				cnt <= cnt - 1;
			if (!start && cnt == 1)
				sample <= '{1'b1, ch, level};
			else
				sample <= '{1'b0, ~sample.chan, ~sample.data};
		end
	end
endmodule // aipp_front_model

// [verification/aipp_postproc_sva.sv]
/*
 * port checker for the post-processing block.
 * assumes it is bound to aipp_postproc with the same count parameters.
 */
`include "aipp_map.svh"
module aipp_postproc_chk
	import aipp_pkg::*;
#(
	parameter int SLOW_CYCLES = 20,
	parameter int FAST_CYCLES = 5
)
(
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	input wire aipp_sample_t SAMPLE,
	input wire logic CONV_START,
	input wire logic [3:0] CONV_CHAN,
	input wire logic CONV_FAST,
	input wire logic [15:0] DISC_FLAGS
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// ==========================================================
	// register port
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0)
		else $error("read data not zero outside read");
	rdata_unmap_a: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h08
		|-> REG_RDATA == 16'h0) else $error("unmapped read not zero");
	rdata_flags_a: assert property ($past(REG_RD)
		&& $past(REG_ADDR) == `AIPP_OFS_DISC_STATUS
		|-> REG_RDATA == $past(DISC_FLAGS)) else $error("flag word wrong");
	fast_write_a: assert property ($past(REG_WR)
		&& $past(REG_ADDR) == `AIPP_OFS_MODE
		|-> CONV_FAST == $past(REG_WDATA[0])) else $error("mode bit lost");
	fast_hold_a: assert property (!$past(REG_WR) |-> $stable(CONV_FAST))
		else $error("mode changed without write");
	// ==========================================================
	// conversion scheduling and flags
	// a period of at least five cycles is assumed of both count parameters
	start_gap_a: assert property (CONV_START |=> !CONV_START [*4])
		else $error("conversion requests too close");
	// a switch to fast mode may legally shorten the running period
	slow_gap_a: assert property (CONV_START && !CONV_FAST
		|=> (!CONV_START || CONV_FAST) [*8])
		else $error("slow period too short");
	chan_moves_a: assert property ($changed(CONV_CHAN) |-> CONV_START)
		else $error("channel changed without request");
	flag_cause_a: assert property ($changed(DISC_FLAGS) |->
		($past(SAMPLE.valid) && (DISC_FLAGS ^ $past(DISC_FLAGS))
		== (16'h0001 << $past(SAMPLE.chan))) || $past(REG_WR))
		else $error("flag changed without sample");
	conv_c: cover property (CONV_START);
	flag_c: cover property ($rose(DISC_FLAGS[0]));
	flagrd_c: cover property (REG_RD && REG_ADDR == 8'h03 && DISC_FLAGS != 0);
endmodule // aipp_postproc_chk

bind aipp_postproc aipp_postproc_chk #(
	.SLOW_CYCLES(SLOW_CYCLES),
	.FAST_CYCLES(FAST_CYCLES)
) chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .SAMPLE(SAMPLE), .CONV_START(CONV_START),
	.CONV_CHAN(CONV_CHAN), .CONV_FAST(CONV_FAST), .DISC_FLAGS(DISC_FLAGS));

// [verification/testbench.sv]
/*
 * self-checking bench: register tasks, response time table, peak hold,
 * disconnection, averaging and scaling through one converter model.
 * assumes short conversion periods set by parameter.
 */
module testbench
	import aipp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr, rd;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, flags, seen;
	logic [3:0] cchan;
	logic start, fast;
	logic signed [15:0] lv;
	aipp_sample_t smp;
	int bad_count, n_tests, cycles;
	logic [63:0] rt [8];
	aipp_postproc #(.SLOW_CYCLES(20), .FAST_CYCLES(5)) uut (.REF_CLK(clk),
		.SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .SAMPLE(smp), .CONV_START(start),
		.CONV_CHAN(cchan), .CONV_FAST(fast), .DISC_FLAGS(flags));
	aipp_front_model front (.clk(clk), .rst(rst), .start(start),
		.chan(cchan), .level(lv), .sample(smp));
	// ==========================================================
	// clock, reset and hang guard
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// the tests need well under 10000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			test_done();
		end
	end
	// ==========================================================
	// tasks
	task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wrr(logic [7:0] a, logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdr(logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 seen = rdata;
	endtask
	// wait for the next sample of input 0 to land in its output word
	task automatic conv(logic signed [15:0] v);
		int i;
		lv <= v;
		i = 0;
		// a sample standing at the first edge may carry the old level
		repeat (2) @(posedge clk);
		while (!(smp.valid === 1'b1 && smp.chan === 4'h0) && i < 200)
		begin
			@(posedge clk);
			i++;
		end
		repeat (2) @(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		lv = 16'sh0;
		cycles = 0;
		// use mask, config, mode, expected response word
		rt = '{64'h0001_0001_0000_0006, 64'h0081_0006_0000_010D,
			64'hFFFF_0000_0000_0048, 64'h0081_0002_0001_001D,
			64'h0001_0003_0001_0016, 64'h0001_0004_0000_0026,
			64'h0007_0005_0000_00C9, 64'hFFFF_0006_0001_07D5};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdr(8'h00); chk("peak bits", seen, 16'h0000);
		rdr(8'h01); chk("input use", seen, 16'hFFFF);
		wrr(8'h03, 16'hFFFF);
		rdr(8'h03); chk("flags ro", seen, 16'h0000);
		rdr(8'h08); chk("unmapped", seen, 16'h0000);
		$display("test registers done");
		foreach (rt[i])
		begin
			wrr(8'h01, rt[i][63:48]);
			wrr(8'h10, rt[i][47:32]);
			wrr(8'h02, rt[i][31:16]);
			rdr(8'h04); chk("response", seen, rt[i][15:0]);
		end
		wrr(8'h02, 16'h0020);
		rdr(8'h04); chk("resp sel", seen, 16'h0048);
		$display("test response time done");
		wrr(8'h02, 16'h0000);
		wrr(8'h01, 16'h0001);
		wrr(8'h10, 16'h0021);
		conv(16'sd1000); rdr(8'h40); chk("live", seen, 16'h03E8);
		wrr(8'h00, 16'h0001);
		conv(16'sd2000); rdr(8'h40); chk("peak", seen, 16'h07D0);
		conv(-16'sd100); rdr(8'h40); chk("peak neg", seen, 16'h07D0);
		conv(-16'sd800); chk("flag set", flags, 16'h0001);
		rdr(8'h40); chk("peak disc", seen, 16'h07D0);
		wrr(8'h00, 16'h0000);
		conv(-16'sd800); rdr(8'h40); chk("disc zero", seen, 16'h0000);
		conv(16'sd300); chk("flag clr", flags, 16'h0000);
		rdr(8'h40); chk("restored", seen, 16'h012C);
		conv(-16'sd700); chk("threshold", flags, 16'h0000);
		wrr(8'h10, 16'h0011);
		conv(-16'sd800); chk("no detect", flags, 16'h0000);
		rdr(8'h40); chk("under", seen, 16'hFCE0);
		wrr(8'h10, 16'h0041);
		conv(-16'sd800); chk("current loop", flags, 16'h0001);
		wrr(8'h02, 16'h0001);
		conv(-16'sd800); chk("fast thr", flags, 16'h0000);
		conv(-16'sd1500); chk("fast disc", flags, 16'h0001);
		wrr(8'h02, 16'h0000);
		$display("test peak and disconnection done");
		lv <= 16'sd1000;
		wrr(8'h10, 16'h0010);
		conv(16'sd1000);
		conv(16'sd1000); rdr(8'h40); chk("mean fill", seen, 16'h03E8);
		wrr(8'h00, 16'h0001);
		conv(16'sd2000); rdr(8'h40); chk("mean", seen, 16'h05DC);
		conv(16'sd0); rdr(8'h40); chk("mean peak", seen, 16'h05DC);
		wrr(8'h00, 16'h0000);
		$display("test averaging done");
		wrr(8'h10, 16'h0011);
		wrr(8'h21, 16'h03E8);
		conv(16'sd2000); rdr(8'h40); chk("scale", seen, 16'h01F4);
		wrr(8'h20, 16'h03E8);
		wrr(8'h21, 16'h0000);
		conv(16'sd1000); rdr(8'h40); chk("reverse", seen, 16'h02EE);
		wrr(8'h20, 16'hFC18);
		wrr(8'h21, 16'h03E8);
		conv(16'sd1000); rdr(8'h40); chk("neg limit", seen, 16'hFE0C);
		wrr(8'h10, 16'h0001);
		conv(16'sd1000); rdr(8'h40); chk("bipolar", seen, 16'h01F4);
		wrr(8'h10, 16'h0011);
		wrr(8'h20, 16'h8300);
		wrr(8'h21, 16'h7D00);
		conv(16'sd4000); rdr(8'h40); chk("wide", seen, 16'h7D00);
		wrr(8'h02, 16'h0001);
		conv(16'sd1000); rdr(8'h40); chk("fast raw", seen, 16'h03E8);
		wrr(8'h20, 16'h0000);
		wrr(8'h21, 16'h0000);
		wrr(8'h02, 16'h0000);
		conv(16'sd1500); rdr(8'h40); chk("bypass", seen, 16'h05DC);
		$display("test scaling done");
		test_done();
	end
endmodule // testbench
